// [verilog/usbis_pkg.sv]
/*
  usbis_pkg: constants and types of the usb device interrupt status block.
  assumes a 250 MHz system clock and a 32-bit register port.
*/
`default_nettype none
package usbis_pkg;
  // register offsets, byte addresses
  localparam logic [7:0] OFS_ENABLE = 8'h00;     // interrupt mask, read/write
  localparam logic [7:0] OFS_STATUS = 8'h04;     // interrupt status, read-only
  localparam logic [7:0] OFS_CLEAR  = 8'h08;     // interrupt clear, write-only
  // field positions
  localparam int NUM_EP      = 6;                // endpoints 0 to 5 in bits 0..5
  localparam int BIT_SUSPEND = 8;
  localparam int BIT_RESUME  = 9;
  localparam int BIT_SOF     = 11;
  localparam int BIT_RSTDONE = 12;
  localparam int BIT_WAKEUP  = 13;
  // bus-level flags that the clear register can reach
  localparam logic [31:0] BUS_FLAG_MASK = 32'h0000_3B00;
  // endpoint flags
  localparam logic [31:0] EP_FLAG_MASK  = 32'h0000_003F;
  // mask bits that always read and act as enabled
  localparam logic [31:0] MASK_FORCED   = 32'h0000_1000;
  // mask reset: resume kept enabled so a powered-down core still wakes
  localparam logic [31:0] MASK_RESET    = 32'h0000_0200;
  // timing
  localparam int CLK_KHZ        = 250000;        // 250 MHz
  localparam int SUSPEND_IDLE_MS = 3;            // idle time before suspend
  localparam int SUSPEND_CYCLES = SUSPEND_IDLE_MS * CLK_KHZ;
  localparam int IDLE_CNT_W     = 24;
  // control/status bits of one endpoint that raise its interrupt
  typedef struct packed {
    logic setupReceived;
    logic receiveBankAFull;
    logic receiveBankBFull;
    logic transmitDone;
    logic stallAcknowledged;
  } usbis_ep_csr_s;
  // bus events from the serial engine, one-cycle pulses except activity
  typedef struct packed {
    logic busActivity;                           // level: line not idle
    logic resumeSeen;                            // resume signalling detected
    logic frameStart;                            // start-of-frame token
    logic busResetDone;                          // end of bus reset
  } usbis_bus_ev_s;
  // link power state
  typedef enum logic {LINK_RUN, LINK_SUSPENDED} usbis_link_e;
endpackage
`default_nettype wire

// [verilog/usbis_irq_status.sv]
/*
  usbis_irq_status: interrupt status, clear and mask logic of a full-speed
  usb device port, with idle-based suspend detection.
  assumes endpoint csr bits and bus events come from logic on sys_clk,
  and a simple register port with read data one cycle after the strobe.
*/
// How it works
// - endpoint 0..5 pending flags in bits 0..5
// - any endpoint csr cause raises its flag
// - endpoint flag follows csr; clear register ignores it
// - 3 ms idle sets bit 8, enters suspend
// - resume signalling sets bit 9
// - every frame start token sets bit 11
// - bus reset end sets bit 12
// - resume or reset sets wakeup bit 13
// - write-only clear register, bits 8,9,11,12,13
// - writing one clears flag, zero keeps it
// - bit 12 of mask always reads one
`timescale 1ns/1ps
`default_nettype none
module usbis_irq_status #(
  parameter int SuspendCycles = usbis_pkg::SUSPEND_CYCLES  // shorten in sim
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  // register port
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWrData,
  input  wire logic                    regWrStb,
  input  wire logic                    regRdStb,
  output logic      [31:0]             regRdData,
  // endpoint control/status bits
  input  wire usbis_pkg::usbis_ep_csr_s epCsr [usbis_pkg::NUM_EP],
  // bus events from the serial engine
  input  wire usbis_pkg::usbis_bus_ev_s busEv,
  // outputs
  output logic                         irq,
  output logic                         linkSuspended
);

  // any cause bit of one endpoint set
  function automatic logic epCause(input usbis_pkg::usbis_ep_csr_s c);
    epCause = c.setupReceived | c.receiveBankAFull | c.receiveBankBFull
            | c.transmitDone | c.stallAcknowledged;
  endfunction

  // register address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // state
  logic [31:0]                      busFlags_q;   // sticky bus-level flags
  logic [31:0]                      busFlags_d;
  logic [usbis_pkg::NUM_EP-1:0]     epPending_q;  // endpoint pending flags
  logic [usbis_pkg::NUM_EP-1:0]     epAny;        // live endpoint causes
  logic [31:0]                      mask_q;       // interrupt enables
  logic [31:0]                      rdData_q;     // registered read data
  logic                             irq_q;        // registered interrupt
  logic [usbis_pkg::IDLE_CNT_W-1:0] idleCnt_q;    // idle cycle counter
  usbis_pkg::usbis_link_e           link_q;       // link power state

  // decode
  wire                wrEnable = regWrStb & hit(regAddr, usbis_pkg::OFS_ENABLE);
  wire                wrClear  = regWrStb & hit(regAddr, usbis_pkg::OFS_CLEAR);
  wire                rdEnable = regRdStb & hit(regAddr, usbis_pkg::OFS_ENABLE);
  wire                rdStatus = regRdStb & hit(regAddr, usbis_pkg::OFS_STATUS);
  wire [31:0]         maskView = mask_q | usbis_pkg::MASK_FORCED;
  wire [31:0]         status   = busFlags_q
                               | {{(32-usbis_pkg::NUM_EP){1'b0}}, epPending_q};
  wire [31:0]         clrBits  = wrClear ? (regWrData & usbis_pkg::BUS_FLAG_MASK)
                                         : 32'h0000_0000;
  // live request ahead of the output flop; the checks below reuse it
  wire                irqLive  = |(status & maskView);
  wire                idleHit  = (link_q == usbis_pkg::LINK_RUN) && !busEv.busActivity
                               && (idleCnt_q == usbis_pkg::IDLE_CNT_W'(SuspendCycles - 1));
  wire [31:0]         setBits;

  // endpoint causes, one OR per endpoint
  genvar g;
  generate
    for (g = 0; g < usbis_pkg::NUM_EP; g++)
    begin : gEp
      assign epAny[g] = epCause(epCsr[g]);
    end
  endgenerate

  // events that set bus-level flags; wakeup on resume or reset
  assign setBits = (32'(idleHit)            << usbis_pkg::BIT_SUSPEND)
                 | (32'(busEv.resumeSeen)   << usbis_pkg::BIT_RESUME)
                 | (32'(busEv.frameStart)   << usbis_pkg::BIT_SOF)
                 | (32'(busEv.busResetDone) << usbis_pkg::BIT_RSTDONE)
                 | (32'(busEv.resumeSeen | busEv.busResetDone)
                    << usbis_pkg::BIT_WAKEUP);

  // set wins over a clear in the same cycle
  assign busFlags_d = (busFlags_q & ~clrBits) | setBits;

  // bus-level sticky flags; resume and wakeup start at zero here,
  // software must still clear them before trusting them
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busFlags_q <= 32'h0000_0000;
    else
      busFlags_q <= busFlags_d & usbis_pkg::BUS_FLAG_MASK;
  end

  // endpoint flags mirror the csr: they drop only when the csr bit is
  // cleared, never through the clear register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      epPending_q <= '0;
    else
      epPending_q <= epAny;
  end

  // mask register; forced bit is stored but always reads one
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mask_q <= usbis_pkg::MASK_RESET;
    else if (wrEnable)
      mask_q <= regWrData & (usbis_pkg::BUS_FLAG_MASK | usbis_pkg::EP_FLAG_MASK);
  end

  // idle counter runs while the line is quiet and the link is awake
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      idleCnt_q <= '0;
    else if (busEv.busActivity || link_q == usbis_pkg::LINK_SUSPENDED)
      idleCnt_q <= '0;
    else if (!idleHit)
      idleCnt_q <= idleCnt_q + 1'b1;
  end

  // link state: suspend on idle, wake on any activity or resume
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      link_q <= usbis_pkg::LINK_RUN;
    else
      case (link_q)
        usbis_pkg::LINK_RUN:
          if (idleHit)
            link_q <= usbis_pkg::LINK_SUSPENDED;
        usbis_pkg::LINK_SUSPENDED:
          if (busEv.busActivity || busEv.resumeSeen)
            link_q <= usbis_pkg::LINK_RUN;
        default:
          link_q <= usbis_pkg::LINK_RUN;
      endcase
  end

  // read data valid only in the cycle after the strobe; clear reads zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData_q <= 32'h0000_0000;
    else if (rdEnable)
      rdData_q <= maskView;
    else if (rdStatus)
      rdData_q <= status;
    else
      rdData_q <= 32'h0000_0000;
  end

  // interrupt level, registered to keep the output glitch free
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= irqLive;
  end

  assign regRdData     = rdData_q;
  assign irq           = irq_q;
  assign linkSuspended = (link_q == usbis_pkg::LINK_SUSPENDED);

  // checks
  sequence s_clrResume;
    wrClear && regWrData[usbis_pkg::BIT_RESUME] && !busEv.resumeSeen;
  endsequence

  property p_ep_pend;
    @(posedge sys_clk) disable iff (!rst_b)
      1 |=> epPending_q == $past(epAny);
  endproperty
  a_ep_pend: assert property (p_ep_pend) else $error("endpoint flag wrong");

  property p_ep_noclr;
    @(posedge sys_clk) disable iff (!rst_b)
      (wrClear && epAny[0]) |=> status[0];
  endproperty
  a_ep_noclr: assert property (p_ep_noclr) else $error("clear hit endpoint");

  property p_susp;
    @(posedge sys_clk) disable iff (!rst_b)
      idleHit |=> busFlags_q[usbis_pkg::BIT_SUSPEND] && linkSuspended;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not entered");

  property p_rsm;
    @(posedge sys_clk) disable iff (!rst_b)
      busEv.resumeSeen |=> busFlags_q[usbis_pkg::BIT_RESUME];
  endproperty
  a_rsm: assert property (p_rsm) else $error("resume flag not set");

  property p_sof;
    @(posedge sys_clk) disable iff (!rst_b)
      busEv.frameStart |=> busFlags_q[usbis_pkg::BIT_SOF];
  endproperty
  a_sof: assert property (p_sof) else $error("frame flag not set");

  // reset end: flag first, then the unmaskable request one cycle later
  sequence s_rstDoneIrq;
    busFlags_q[usbis_pkg::BIT_RSTDONE] ##1 irq;
  endsequence

  property p_rstdone;
    @(posedge sys_clk) disable iff (!rst_b)
      busEv.busResetDone |=> s_rstDoneIrq;
  endproperty
  a_rstdone: assert property (p_rstdone) else $error("reset-done flag not set");

  property p_wake;
    @(posedge sys_clk) disable iff (!rst_b)
      (busEv.resumeSeen || busEv.busResetDone) |=> busFlags_q[usbis_pkg::BIT_WAKEUP];
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup flag not set");

  property p_clr;
    @(posedge sys_clk) disable iff (!rst_b)
      s_clrResume |=> !busFlags_q[usbis_pkg::BIT_RESUME];
  endproperty
  a_clr: assert property (p_clr) else $error("resume flag not cleared");

  property p_mask12;
    @(posedge sys_clk) disable iff (!rst_b)
      rdEnable |=> regRdData[usbis_pkg::BIT_RSTDONE];
  endproperty
  a_mask12: assert property (p_mask12) else $error("bit 12 of mask not one");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_b)
      1 |=> irq == $past(irqLive);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  // a zero in the clear word leaves a raised frame flag alone
  sequence s_keepSof;
    wrClear && !regWrData[usbis_pkg::BIT_SOF] && busFlags_q[usbis_pkg::BIT_SOF];
  endsequence

  property p_keep;
    @(posedge sys_clk) disable iff (!rst_b)
      s_keepSof |=> busFlags_q[usbis_pkg::BIT_SOF];
  endproperty
  a_keep: assert property (p_keep) else $error("zero clear bit dropped frame flag");

  // a one clears the frame flag unless a new token lands in the same cycle
  property p_clr_sof;
    @(posedge sys_clk) disable iff (!rst_b)
      (wrClear && regWrData[usbis_pkg::BIT_SOF] && !busEv.frameStart) |=> !busFlags_q[usbis_pkg::BIT_SOF];
  endproperty
  a_clr_sof: assert property (p_clr_sof) else $error("frame flag not cleared");

  // clear register is write-only: reading it returns zero
  property p_clr_rd;
    @(posedge sys_clk) disable iff (!rst_b)
      (regRdStb && regAddr == usbis_pkg::OFS_CLEAR) |=> regRdData == 32'h0000_0000;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear register read not zero");

  // status never shows a bit outside the endpoint and bus-level fields
  property p_spare;
    @(posedge sys_clk) disable iff (!rst_b)
      rdStatus |=> (regRdData & ~(usbis_pkg::BUS_FLAG_MASK | usbis_pkg::EP_FLAG_MASK)) == 32'h0000_0000;
  endproperty
  a_spare: assert property (p_spare) else $error("unused status bit set");

  // a busy line never leaves or puts the link in suspend
  property p_busy;
    @(posedge sys_clk) disable iff (!rst_b)
      busEv.busActivity |=> !linkSuspended;
  endproperty
  a_busy: assert property (p_busy) else $error("suspended while line busy");

  // a quiet line with no resume keeps the link suspended
  property p_idle_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      (linkSuspended && !busEv.busActivity && !busEv.resumeSeen) |=> linkSuspended;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("left suspend without activity");

endmodule // usbis_irq_status
`default_nettype wire

// [tb/usbis_host_model.sv]
/*
  usbis_host_model: stands in for the usb host at the bus side of the block.
  assumes the bench calls its tasks from one process, synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module usbis_host_model (
  // clock
  input  wire logic                     sys_clk,
  // bus events toward the device
  output var  usbis_pkg::usbis_bus_ev_s busEv
);
  // line busy from the start so the idle counter never runs unasked
  initial busEv = 4'h8;

  // one-cycle signalling pulse: 0 resume, 1 frame start, 2 reset end
  task automatic send(input int kind);
    @(posedge sys_clk);
    busEv.resumeSeen   <= (kind == 0);
    busEv.frameStart   <= (kind == 1);
    busEv.busResetDone <= (kind == 2);
    @(posedge sys_clk);
    busEv.resumeSeen   <= 1'b0;
    busEv.frameStart   <= 1'b0;
    busEv.busResetDone <= 1'b0;
  endtask

  // idle line: 1 stops all host traffic to force suspend, 0 makes the line busy again
  task automatic go_idle(input logic idle);
    @(posedge sys_clk);
    busEv.busActivity <= ~idle;
  endtask
endmodule // usbis_host_model
`default_nettype wire

// [tb/usb_device_interrupt_status_bench.sv]
/*
  usb_device_interrupt_status_bench: self-checking bench of usbis_irq_status.
  assumes mask at 0x00, status 0x04, clear 0x08 and a short suspend count.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_device_interrupt_status_bench;
  localparam int Susp = 20;                        // short idle count
  logic                    sys_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic [7:0]              regAddr = 8'h00;
  logic [31:0]             regWrData = 32'h0;
  logic                    regWrStb = 1'b0;
  logic                    regRdStb = 1'b0;
  logic [31:0]             regRdData;
  usbis_pkg::usbis_ep_csr_s epCsr [usbis_pkg::NUM_EP] = '{default: 5'h00};
  usbis_pkg::usbis_bus_ev_s busEv;
  logic                    irq;
  logic                    linkSuspended;
  int                      err_total = 0;
  int                      n_checks = 0;
  int                      cycles = 0;
  logic [31:0]             rdv;
  logic [31:0]             evExp [3] = '{32'h0000_2200, 32'h0000_0800, 32'h0000_3000};

  always #2 sys_clk = ~sys_clk;                    // 250 MHz

  usbis_host_model u_host (.sys_clk(sys_clk), .busEv(busEv));

  usbis_irq_status #(.SuspendCycles(Susp)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .epCsr(epCsr),
    .busEv(busEv), .irq(irq), .linkSuspended(linkSuspended));

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb  <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 rdv = regRdData;
  endtask

  // word compare, single flags passed zero-extended
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // verdict, the single exit point
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard: the tests need well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    wr(8'h08, 32'h0000_2200);
    rd(8'h04);
    chk("status", 32'h0, rdv);
    rd(8'h00);
    chk("mask", 32'h0000_1200, rdv);
    rd(8'h08);
    chk("clear", 32'h0, rdv);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC);
    chk("unmapped", 32'h0, rdv);
    $display("test reset done");
    // bus events: set, write zero keeps, write one clears
    for (int k = 0; k < 3; k++)
    begin
      u_host.send(k);
      rd(8'h04);
      chk("event", evExp[k], rdv);
      chk("irq", {31'h0, (evExp[k] & 32'h1200) != 0}, {31'h0, irq});
      wr(8'h08, ~evExp[k] & 32'h0000_3B00);
      rd(8'h04);
      chk("keep", evExp[k], rdv);
      wr(8'h08, evExp[k]);
      rd(8'h04);
      chk("clr", 32'h0, rdv);
      chk("irq", 32'h0, {31'h0, irq});
    end
    $display("test events done");
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk("mask", 32'h0000_1000, rdv);
    // endpoint flags follow their csr causes, clear register cannot touch them;
    // the host talks to endpoint 0 first once its bus reset has ended
    wr(8'h00, 32'h0000_003F);
    for (int i = 0; i < usbis_pkg::NUM_EP; i++)
    begin
      @(posedge sys_clk);
      epCsr[i] <= usbis_pkg::usbis_ep_csr_s'(5'h10 >> (i % 5));
      rd(8'h04);
      chk("ep", 32'h1 << i, rdv);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h04);
      chk("ep", 32'h1 << i, rdv);
      @(posedge sys_clk);
      epCsr[i] <= 5'h00;
      rd(8'h04);
      chk("ep", 32'h0, rdv);
      chk("irq", 32'h0, {31'h0, irq});
    end
    $display("test endpoints done");
    // idle line leads to suspend
    wr(8'h00, 32'h0000_0100);
    u_host.go_idle(1'b1);
    repeat (Susp + 10) @(posedge sys_clk);
    rd(8'h04);
    chk("suspend", 32'h0000_0100, rdv);
    chk("link", 32'h1, {31'h0, linkSuspended});
    chk("irq", 32'h1, {31'h0, irq});
    u_host.go_idle(1'b0);
    wr(8'h08, 32'h0000_0100);
    rd(8'h04);
    chk("suspend", 32'h0, rdv);
    chk("link", 32'h0, {31'h0, linkSuspended});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test suspend done");
    complete_run();
  end
endmodule // usb_device_interrupt_status_bench
`default_nettype wire
